// >>> design/hall_trapezoidal_commutation.sv
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module hall_trapezoidal_commutation
   import hall_commutation_pkg::*;
#(
   parameter int window_cycles = speed_window_cycles
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // hall sources per channel {third, second, first}
   input wire logic [2:0] hall_conn_ch0,
   input wire logic [2:0] hall_conn_ch1,
   input wire logic [2:0] hall_dig_ch0,
   input wire logic [2:0] hall_dig_ch1,
   // phase drives per channel {w, v, u}
   output logic [2:0] phase_high_ch0,
   output logic [2:0] phase_low_ch0,
   output logic [2:0] phase_high_ch1,
   output logic [2:0] phase_low_ch1,
   // interrupt and error
   output logic irq,
   output logic [1:0] sensor_error
);

   // ==========================================
   // functions
   // permutation of {third,second,first}
   function automatic logic [2:0] permute(input logic [2:0] h, input logic [2:0] m);
      case (m)
         3'h0: permute = h;
         3'h1: permute = {h[1], h[2], h[0]};
         3'h2: permute = {h[2], h[0], h[1]};
         3'h3: permute = {h[0], h[1], h[2]};
         3'h4: permute = {h[0], h[2], h[1]};
         3'h5: permute = {h[1], h[0], h[2]};
         default: permute = h;
      endcase
   endfunction : permute

   // sector 0..5, 3'h7 when invalid
   function automatic logic [2:0] sector_of(input logic [2:0] h, input logic sixty);
      logic [2:0] s;
      s = 3'h7;
      if (sixty) begin
         case (h) // [RQ4]
            3'h0: s = 3'h0;
            3'h1: s = 3'h1;
            3'h3: s = 3'h2;
            3'h7: s = 3'h3;
            3'h6: s = 3'h4;
            3'h4: s = 3'h5;
            default: s = 3'h7;
         endcase
      end else begin
         // first=U-W, second=V-U, third=W-V sequence [RQ11]
         case (h) // [RQ3]
            3'h1: s = 3'h0;
            3'h3: s = 3'h1;
            3'h2: s = 3'h2;
            3'h6: s = 3'h3;
            3'h4: s = 3'h4;
            3'h5: s = 3'h5;
            default: s = 3'h7;
         endcase
      end
      sector_of = s;
   endfunction : sector_of

   // drive pair {high[2:0], low[2:0]}, reversed swaps polarity
   function automatic logic [5:0] drive_of(input logic [2:0] s, input logic rev);
      logic [5:0] d;
      case (s) // [RQ1]
         3'h0: d = {3'b001, 3'b100};
         3'h1: d = {3'b010, 3'b100};
         3'h2: d = {3'b010, 3'b001};
         3'h3: d = {3'b100, 3'b001};
         3'h4: d = {3'b100, 3'b010};
         3'h5: d = {3'b001, 3'b010};
         default: d = 6'h00; // [RQ12]
      endcase
      drive_of = rev ? {d[2:0], d[5:3]} : d;
   endfunction : drive_of

   // ==========================================
   // input synchronisers, on both sources ahead of the source select
   // the select sits after the second flop so no logic ever reads a raw pin
   logic [2:0] conn_pin [n_chan];
   logic [2:0] dig_pin [n_chan];
   logic [2:0] conn_s1_reg [n_chan];
   logic [2:0] conn_s2_reg [n_chan];
   logic [2:0] dig_s1_reg [n_chan];
   logic [2:0] dig_s2_reg [n_chan];
   // pins gathered into per-channel arrays
   assign conn_pin[0] = hall_conn_ch0;
   assign conn_pin[1] = hall_conn_ch1;
   assign dig_pin[0] = hall_dig_ch0;
   assign dig_pin[1] = hall_dig_ch1;
   // two flops on every hall line
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < n_chan; i++) begin
            conn_s1_reg[i] <= 3'h0;
            conn_s2_reg[i] <= 3'h0;
            dig_s1_reg[i] <= 3'h0;
            dig_s2_reg[i] <= 3'h0;
         end
      end else begin
         for (int i = 0; i < n_chan; i++) begin
            conn_s1_reg[i] <= conn_pin[i];
            conn_s2_reg[i] <= conn_s1_reg[i];
            dig_s1_reg[i] <= dig_pin[i];
            dig_s2_reg[i] <= dig_s1_reg[i];
         end
      end
   end

   // ==========================================
   // registers and state
   logic [31:0] ctrl_reg, ctrl_next;
   logic signed [7:0] pole_reg, pole_next;
   logic [2:0] state_reg [n_chan];
   logic [2:0] state_next [n_chan];
   logic [2:0] sect_reg [n_chan];
   logic [2:0] sect_next [n_chan];
   logic signed [15:0] count_reg [n_chan];
   logic signed [15:0] count_next [n_chan];
   logic signed [15:0] tcount_reg [n_chan];
   logic signed [15:0] tcount_next [n_chan];
   logic signed [15:0] speed_reg [n_chan];
   logic signed [15:0] speed_next [n_chan];
   logic signed [15:0] win_reg [n_chan];
   logic signed [15:0] win_next [n_chan];
   logic [31:0] timer_reg, timer_next;
   logic [3:0] status_reg, status_next;
   logic [3:0] mask_reg, mask_next;
   logic [2:0] hi_reg [n_chan];
   logic [2:0] hi_next [n_chan];
   logic [2:0] lo_reg [n_chan];
   logic [2:0] lo_next [n_chan];
   logic [31:0] prdata_next;
   logic pready_next;
   logic irq_next;
   logic [1:0] err_next;

   // ==========================================
   // next-state logic
   always_comb begin
      logic wr;
      logic tick;
      logic [2:0] h;
      logic [2:0] sec;
      logic [5:0] d;
      logic signed [15:0] step;
      logic signed [15:0] div;
      logic [3:0] ev;
      // defaults so that no path leaves a local undriven
      h = 3'h0;
      sec = 3'h7;
      d = 6'h00;
      step = 16'sh0;
      div = 16'sh6;
      // a write lands on the completion edge, where pready is sampled high
      wr = psel && penable && pwrite && pready;
      tick = (timer_reg == window_cycles - 1);
      ev = 4'h0;
      ctrl_next = ctrl_reg;
      pole_next = pole_reg;
      mask_next = mask_reg;
      timer_next = tick ? 32'h0 : timer_reg + 32'h1;
      // magnitude times six as divisor [RQ7] [RQ8]
      div = 16'(steps_per_turn) * 16'(pole_reg < 0 ? -pole_reg : pole_reg);
      if (div == 16'sh0) begin
         div = 16'sh6;
      end
      for (int i = 0; i < n_chan; i++) begin
         // source select on synchronised lines, then the order map [RQ10]
         h = permute(ctrl_reg[i*chan_stride + source_bit] ? dig_s2_reg[i] : conn_s2_reg[i],
                     ctrl_reg[i*chan_stride + map_lsb +: 3]); // [RQ6]
         sec = sector_of(h, ctrl_reg[i*chan_stride + spacing_bit]); // [RQ5]
         state_next[i] = h; // [RQ2]
         sect_next[i] = sec;
         // drive ignores the pole-pair setting [RQ9]
         d = drive_of(sec, ctrl_reg[i*chan_stride + reverse_bit]);
         hi_next[i] = d[5:3];
         lo_next[i] = d[2:0];
         step = 16'sh0;
         if (sec != 3'h7 && sect_reg[i] != 3'h7 && sec != sect_reg[i]) begin
            step = (sec == sect_reg[i] + 3'h1 || (sec == 3'h0 && sect_reg[i] == 3'h5))
                   ? 16'sh1 : -16'sh1;
            if (pole_reg < 0) begin
               step = -step; // [RQ8]
            end
            ev[i] = 1'b1;
         end
         if (sec == 3'h7 && sect_reg[i] != 3'h7) begin
            ev[2 + i] = 1'b1; // [RQ12]
         end
         count_next[i] = count_reg[i] + step; // [RQ7]
         tcount_next[i] = count_reg[i] / div; // [RQ7]
         win_next[i] = tick ? step : win_reg[i] + step;
         speed_next[i] = tick ? win_reg[i] / div : speed_reg[i]; // [RQ7] [RQ8]
      end
      status_next = status_reg;
      if (wr && paddr == ctrl_offset) begin
         ctrl_next = pwdata;
      end
      if (wr && paddr == pole_offset) begin
         pole_next = pwdata[7:0];
      end
      if (wr && paddr == mask_offset) begin
         mask_next = pwdata[3:0];
      end
      if (wr && paddr == status_offset) begin
         status_next = status_reg & ~pwdata[3:0];
      end
      status_next = status_next | ev; // set wins over clear
      irq_next = |(status_next & mask_next);
      // read mux: loaded once on the first access edge, then held for the master
      // so that live counters cannot move under a read in progress
      prdata_next = prdata;
      if (psel && penable && !pready) begin
         case (paddr)
            ctrl_offset: prdata_next = ctrl_reg;
            pole_offset: prdata_next = {{24{pole_reg[7]}}, pole_reg};
            // per 16-bit half: sector in [10:8], mapped hall state in [2:0]
            sector_offset: prdata_next = {5'h0, sect_reg[1], 5'h0, state_reg[1], 5'h0,
                                          sect_reg[0], 5'h0, state_reg[0]};
            count_offset: prdata_next = {count_reg[1], count_reg[0]};
            turns_offset: prdata_next = {tcount_reg[1], tcount_reg[0]};
            speed_offset: prdata_next = {speed_reg[1], speed_reg[0]};
            status_offset: prdata_next = {28'h0, status_reg};
            mask_offset: prdata_next = {28'h0, mask_reg};
            default: prdata_next = 32'h0;
         endcase
      end
      // one wait state: pready answers the edge after the access phase starts
      pready_next = psel && penable && !pready;
      // error flags registered on the same edge as the sector they describe
      err_next = {sect_next[1] == 3'h7, sect_next[0] == 3'h7}; // [RQ12]
   end

   // ==========================================
   // state registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= ctrl_reset;
         pole_reg <= pole_reset;
         mask_reg <= 4'h0;
         status_reg <= 4'h0;
         timer_reg <= 32'h0;
         prdata <= 32'h0;
         pready <= 1'b0;
         irq <= 1'b0;
         pslverr <= 1'b0;
         sensor_error <= 2'b11;
         for (int i = 0; i < n_chan; i++) begin
            state_reg[i] <= 3'h0;
            sect_reg[i] <= 3'h7;
            count_reg[i] <= 16'sh0;
            tcount_reg[i] <= 16'sh0;
            speed_reg[i] <= 16'sh0;
            win_reg[i] <= 16'sh0;
            hi_reg[i] <= 3'h0;
            lo_reg[i] <= 3'h0;
         end
      end else begin
         ctrl_reg <= ctrl_next;
         pole_reg <= pole_next;
         mask_reg <= mask_next;
         status_reg <= status_next;
         timer_reg <= timer_next;
         prdata <= prdata_next;
         pready <= pready_next;
         irq <= irq_next;
         // no access is ever refused
         pslverr <= 1'b0;
         sensor_error <= err_next;
         for (int i = 0; i < n_chan; i++) begin
            state_reg[i] <= state_next[i];
            sect_reg[i] <= sect_next[i];
            count_reg[i] <= count_next[i];
            tcount_reg[i] <= tcount_next[i];
            speed_reg[i] <= speed_next[i];
            win_reg[i] <= win_next[i];
            hi_reg[i] <= hi_next[i];
            lo_reg[i] <= lo_next[i];
         end
      end
   end

   // ==========================================
   // outputs
   assign phase_high_ch0 = hi_reg[0];
   assign phase_low_ch0 = lo_reg[0];
   assign phase_high_ch1 = hi_reg[1];
   assign phase_low_ch1 = lo_reg[1];
endmodule : hall_trapezoidal_commutation
`default_nettype wire

// >>> shared/hall_commutation_pkg.sv
// Behaviour
// [RQ1] exactly two phases are driven at a time, one high and one low, in six steps chosen by sector.
// [RQ2] the sampled hall state of each channel reads back as a value 0 to 7, one bit per sensor.
// [RQ3] with 120-degree spacing codes 1 to 6 are valid and 0 and 7 are invalid.
// [RQ4] with 60-degree spacing codes 0,1,3,4,6,7 are valid and 2 and 5 are invalid.
// [RQ5] a per-channel bit selects 120-degree or 60-degree spacing for sector decoding.
// [RQ6] a per-channel map value 0 to 5 picks one of six permutations of the three sensor inputs.
// [RQ7] hall transitions are counted, six per electrical turn, and turns and speed use six times pole pairs.
// [RQ8] a negative pole-pair count inverts speed sign and count direction, using its magnitude.
// [RQ9] commutation does not depend on the pole-pair setting.
// [RQ10] a per-channel bit takes hall inputs from the sensor connector or from general digital inputs.
// [RQ11] clockwise sequence assumes first sensor follows U-W, second V-U, third W-V.
// [RQ12] an invalid code turns off all phases of that channel and flags a sensor error until valid.
package hall_commutation_pkg;
   // ==========================================
   // register map (byte addresses)
   localparam logic [7:0] ctrl_offset = 8'h00;
   localparam logic [7:0] pole_offset = 8'h04;
   localparam logic [7:0] sector_offset = 8'h08;
   localparam logic [7:0] count_offset = 8'h0c;
   localparam logic [7:0] turns_offset = 8'h10;
   localparam logic [7:0] speed_offset = 8'h14;
   localparam logic [7:0] status_offset = 8'h18;
   localparam logic [7:0] mask_offset = 8'h1c;
   // ==========================================
   // ctrl fields: per channel byte {dir, source, spacing, map[2:0]}
   localparam int map_lsb = 0;
   localparam int spacing_bit = 3;
   localparam int source_bit = 4;
   localparam int reverse_bit = 5;
   localparam int chan_stride = 8;
   localparam logic [31:0] ctrl_reset = 32'h0000_0000;
   localparam logic signed [7:0] pole_reset = 8'sh01;
   // ==========================================
   // speed window: 125 MHz clock, window in microseconds
   localparam int clk_mhz = 125;
   localparam int speed_window_us = 10000;
   localparam int speed_window_cycles = clk_mhz * speed_window_us;
   localparam int n_chan = 2;
   localparam int steps_per_turn = 6;
endpackage : hall_commutation_pkg

// >>> verification/hall_commutation_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bus handshake and phase drive checks
module hall_commutation_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // bus
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // drives and flags
   input wire logic [2:0] phase_high_ch0,
   input wire logic [2:0] phase_low_ch0,
   input wire logic [2:0] phase_high_ch1,
   input wire logic [2:0] phase_low_ch1,
   input wire logic irq,
   input wire logic [1:0] sensor_error
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   // one wait state, single-cycle answer
   a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("late pready");
   a_ready_pulse: assert property (pready |=> !pready) else $error("long pready");
   a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
   a_no_slverr: assert property (!pslverr) else $error("slverr raised");
   a_rdata_hold: assert property (!(psel && penable) |=> $stable(prdata)) else $error("prdata moved");
   // two phases driven, one high one low, on different legs, unless a sensor error turns all off
   a_pair_ch0: assert property (!sensor_error[0] |-> $onehot(phase_high_ch0) &&
      $onehot(phase_low_ch0) && (phase_high_ch0 & phase_low_ch0) == 3'h0) else $error("ch0 pair");
   a_pair_ch1: assert property (!sensor_error[1] |-> $onehot(phase_high_ch1) &&
      $onehot(phase_low_ch1) && (phase_high_ch1 & phase_low_ch1) == 3'h0) else $error("ch1 pair");
   a_off_on_err: assert property (sensor_error[0] |-> {phase_high_ch0, phase_low_ch0} == 6'h00)
      else $error("ch0 driven on error");
   a_off_err_ch1: assert property (sensor_error[1] |-> {phase_high_ch1, phase_low_ch1} == 6'h00)
      else $error("ch1 driven on error");
   // main scenarios
   c_ready: cover property (pready);
   c_irq: cover property ($rose(irq));
   c_valid: cover property ($fell(sensor_error[0]));
endmodule : hall_commutation_monitor
bind hall_trapezoidal_commutation hall_commutation_monitor i_mon (.clk, .arst_n, .psel, .penable,
   .prdata, .pready, .pslverr, .phase_high_ch0, .phase_low_ch0, .phase_high_ch1, .phase_low_ch1,
   .irq, .sensor_error);
`default_nettype wire

// >>> verification/hall_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// motor hall sensors, open collector lines with pull-ups
module hall_sensor_model (
   // clock
   input wire logic clk,
   // sensor lines {third, second, first}
   output logic [2:0] conn_ch0,
   output logic [2:0] conn_ch1,
   output logic [2:0] dig_ch0,
   output logic [2:0] dig_ch1
);
   // six 60-degree sectors of one electrical turn, 120-degree spacing
   logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
   int pos = 0;
   // unconnected lines float to the pull-up level
   initial begin
      conn_ch0 = 3'h7;
      conn_ch1 = 3'h7;
      dig_ch0 = 3'h7;
      dig_ch1 = 3'h7;
   end
   // present one code on one channel and source
   task automatic put(input int ch, input logic dig, input logic [2:0] code);
      @(posedge clk);
      case ({ch[0], dig})
         2'b00: conn_ch0 <= code;
         2'b01: dig_ch0 <= code;
         2'b10: conn_ch1 <= code;
         default: dig_ch1 <= code;
      endcase
   endtask : put
   // rotate channel 0 forward by n sectors
   task automatic turn(input int n);
      repeat (n) begin
         pos = (pos + 1) % 6;
         put(0, 1'b0, seq[pos]);
         repeat (6) @(posedge clk);
      end
   endtask : turn
endmodule : hall_sensor_model
`default_nettype wire

// >>> verification/tb_hall_trapezoidal_commutation.sv
`timescale 1ns/1ps
`default_nettype none
module tb_hall_trapezoidal_commutation;
   import hall_commutation_pkg::*;
   // ==========================================
   // signals
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, irq;
   logic [1:0] sensor_error;
   logic [2:0] c0, c1, d0, d1, h0, l0, h1, l1;
   logic [15:0] s;
   int error_cnt = 0;
   int compares = 0;
   always #4 clk = ~clk;
   // ==========================================
   // sensor model and block
   hall_sensor_model i_motor (.clk(clk), .conn_ch0(c0), .conn_ch1(c1), .dig_ch0(d0), .dig_ch1(d1));
   hall_trapezoidal_commutation #(.window_cycles(100)) i_dut (.clk(clk), .arst_n(arst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .hall_conn_ch0(c0),
      .hall_conn_ch1(c1), .hall_dig_ch0(d0), .hall_dig_ch1(d1), .phase_high_ch0(h0),
      .phase_low_ch0(l0), .phase_high_ch1(h1), .phase_low_ch1(l1), .irq(irq),
      .sensor_error(sensor_error));
   // ==========================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic results;
      $display("errors=%0d compares=%0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   // one bus transfer, held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // pready and read data are taken at the rising edge, as the slave sees them
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         results();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic settle;
      repeat (5) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic do_reset;
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
   endtask : do_reset
   // ==========================================
   // scenarios
   task automatic t_reset;
      apb(1'b0, ctrl_offset, 32'h0);
      chk(rd, ctrl_reset);
      apb(1'b0, pole_offset, 32'h0);
      chk(rd, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0);
      chk(32'(sensor_error), 32'h3);
   endtask : t_reset
   task automatic t_decode;
      logic inv;
      for (int sp = 0; sp < 2; sp++) begin
         apb(1'b1, ctrl_offset, 32'(sp) << spacing_bit);
         for (int c = 0; c < 8; c++) begin
            i_motor.put(0, 1'b0, 3'(c));
            settle;
            inv = (sp == 1) ? (c == 2 || c == 5) : (c == 0 || c == 7);
            chk(32'(sensor_error[0]), 32'(inv));
            apb(1'b0, sector_offset, 32'h0);
            chk(32'(rd[2:0]), 32'(c));
            chk(32'(rd[10:8] == 3'h7), 32'(inv));
         end
      end
   endtask : t_decode
   // every map is a permutation: a lone bit lands twice on each position
   task automatic t_map;
      int cnt [3];
      cnt = '{0, 0, 0};
      i_motor.put(0, 1'b0, 3'h1);
      for (int m = 0; m < 6; m++) begin
         apb(1'b1, ctrl_offset, 32'(m));
         settle;
         apb(1'b0, sector_offset, 32'h0);
         for (int b = 0; b < 3; b++) cnt[b] += int'(rd[b]);
      end
      for (int b = 0; b < 3; b++) chk(32'(cnt[b]), 32'h2);
   endtask : t_map
   // reverse swaps the high and low leg; pole pairs leave the drive alone
   task automatic t_reverse;
      logic [2:0] hs, ls;
      i_motor.put(0, 1'b0, 3'h3);
      apb(1'b1, ctrl_offset, 32'h0);
      settle;
      hs = h0;
      ls = l0;
      chk(32'($countones({h0, l0})), 32'h2);
      apb(1'b1, ctrl_offset, 32'h1 << reverse_bit);
      settle;
      chk(32'({h0, l0}), 32'({ls, hs}));
      apb(1'b1, pole_offset, 32'hfe);
      settle;
      chk(32'({h0, l0}), 32'({ls, hs}));
   endtask : t_reverse
   task automatic t_source;
      i_motor.put(1, 1'b1, 3'h5);
      apb(1'b1, ctrl_offset, 32'h1 << (chan_stride + source_bit));
      settle;
      chk(32'(sensor_error[1]), 32'h0);
      apb(1'b1, ctrl_offset, 32'h0);
      settle;
      chk(32'(sensor_error[1]), 32'h1);
   endtask : t_source
   task automatic t_count;
      i_motor.put(0, 1'b0, 3'h1);
      do_reset;
      settle;
      apb(1'b1, mask_offset, 32'h1);
      i_motor.turn(12);
      apb(1'b0, count_offset, 32'h0);
      s = rd[15:0];
      chk(32'(s), 32'h0000_000c);
      apb(1'b0, turns_offset, 32'h0);
      chk(32'(rd[15:0]), 32'h2);
      @(negedge clk);
      chk(32'(irq), 32'h1);
      apb(1'b1, mask_offset, 32'h0);
      @(negedge clk);
      chk(32'(irq), 32'h0);
      apb(1'b1, mask_offset, 32'h1);
      @(negedge clk);
      chk(32'(irq), 32'h1);
      apb(1'b1, status_offset, 32'h1);
      @(negedge clk);
      chk(32'(irq), 32'h0);
      apb(1'b1, pole_offset, 32'hff);
      // 36 steps of 7 cycles: the last 100-cycle window before the read holds 14 or 15
      i_motor.turn(36);
      apb(1'b0, count_offset, 32'h0);
      chk(32'(rd[15:0]), 32'hffe8);
      apb(1'b0, speed_offset, 32'h0);
      chk(32'(rd[15:0]), 32'hfffe);
   endtask : t_count
   // ==========================================
   // main sequence
   initial begin
      do_reset;
      t_reset;
      t_decode;
      t_map;
      t_reverse;
      t_source;
      t_count;
      results;
   end
endmodule : tb_hall_trapezoidal_commutation
`default_nettype wire
